// >>> pkg/pte_pkg.sv
package pte_pkg;

  // bank size and bus widths
  localparam int NGEN      = 4;
  localparam int GI_W      = 2;
  localparam int ADDR_W    = 8;
  localparam int DATA_W    = 32;
  localparam int PAT_W     = 32;
  localparam int IDX_W     = 5;
  localparam int LOOP_W    = 16;
  localparam int DIV_SEL_W = 3;
  localparam int CNT_W     = 8;

  // global register offsets
  localparam logic [ADDR_W-1:0] REG_ENABLE = 8'h00;
  localparam logic [ADDR_W-1:0] REG_ENSET  = 8'h04;
  localparam logic [ADDR_W-1:0] REG_ENCLR  = 8'h08;
  localparam logic [ADDR_W-1:0] REG_START  = 8'h0c;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h10;
  localparam logic [ADDR_W-1:0] REG_CLKSEL = 8'h14;
  localparam logic [ADDR_W-1:0] REG_PINSEL = 8'h18;

  // per-generator window: 8'h40 + 16*index + 4*sub
  localparam logic [1:0] GEN_REGION   = 2'h1;
  localparam int         ADDR_REG_LSB = 6;
  localparam int         ADDR_GEN_LSB = 4;
  localparam int         ADDR_SUB_LSB = 2;
  localparam logic [1:0] SUB_CFG      = 2'h0;
  localparam logic [1:0] SUB_PAT      = 2'h1;
  localparam logic [1:0] SUB_LOOPS    = 2'h2;
  localparam logic [1:0] SUB_CHAIN    = 2'h3;

  // field positions
  localparam int CFG_LEN_LSB  = 0;
  localparam int CFG_DIV_LSB  = 8;
  localparam int CFG_SQ_BIT   = 12;
  localparam int CFG_IDLE_BIT = 13;
  localparam int STAT_DONE_LSB = 4;

  // limits and special values
  localparam logic [IDX_W-1:0]  MIN_LEN_M1   = 5'h01;
  localparam logic [LOOP_W-1:0] LOOP_FOREVER = 16'h0000;
  localparam logic [CNT_W-1:0]  CNT_ONE      = 8'h01;

  typedef struct packed {
    logic                 idle;
    logic                 square;
    logic [DIV_SEL_W-1:0] divSel;
    logic [IDX_W-1:0]     lenM1;
  } pte_cfg_t;

  typedef struct packed {
    logic              running;
    logic [IDX_W-1:0]  idx;
    logic [LOOP_W-1:0] loopCnt;
  } pte_gen_t;

  // last bit index; square wave is a fixed two-bit pattern
  function automatic logic [IDX_W-1:0] effLenM1(pte_cfg_t c);
    if (c.square) return MIN_LEN_M1;
    return (c.lenM1 < MIN_LEN_M1) ? MIN_LEN_M1 : c.lenM1;
  endfunction : effLenM1

  function automatic logic patBit(pte_cfg_t c, logic [PAT_W-1:0] p,
                                  logic [IDX_W-1:0] idx);
    if (c.square) return (idx == '0);
    return p[idx];
  endfunction : patBit

  // divide by 2 << divSel, so 2, 4, 8 ... 256
  function automatic logic [CNT_W-1:0] divLimit(logic [DIV_SEL_W-1:0] s);
    logic [CNT_W:0] v;
    v = 9'h002 << s;
    return CNT_W'(v - 9'h001);
  endfunction : divLimit

  function automatic logic [DATA_W-1:0] cfgToWord(pte_cfg_t c);
    logic [DATA_W-1:0] w;
    w = '0;
    w[CFG_LEN_LSB +: IDX_W]     = c.lenM1;
    w[CFG_DIV_LSB +: DIV_SEL_W] = c.divSel;
    w[CFG_SQ_BIT]               = c.square;
    w[CFG_IDLE_BIT]             = c.idle;
    return w;
  endfunction : cfgToWord

  function automatic pte_cfg_t wordToCfg(logic [DATA_W-1:0] w);
    pte_cfg_t c;
    c.lenM1  = w[CFG_LEN_LSB +: IDX_W];
    c.divSel = w[CFG_DIV_LSB +: DIV_SEL_W];
    c.square = w[CFG_SQ_BIT];
    c.idle   = w[CFG_IDLE_BIT];
    return c;
  endfunction : wordToCfg

endpackage : pte_pkg

// >>> rtl/pte_div.sv
`timescale 1ns/1ps
module pte_div
  import pte_pkg::*;
(
  // clock and reset
  input  wire logic                 mclk,
  input  wire logic                 reset_n,
  // rate control
  input  wire logic                 modTick,
  input  wire logic                 restart,
  input  wire logic [DIV_SEL_W-1:0] divSel,
  // bit rate enable
  output logic                      bitTick
);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic             tick;
  } pte_div_t;

  pte_div_t st;
  pte_div_t next_st;

  // restart presets the phase so the first bit is as long as the rest
  always_comb begin
    next_st      = st;
    next_st.tick = 1'b0;
    if (restart) begin
      next_st.cnt = modTick ? CNT_ONE : '0;
    end else if (modTick) begin
      if (st.cnt >= divLimit(divSel)) begin
        next_st.cnt  = '0;
        next_st.tick = 1'b1;
      end else begin
        next_st.cnt = st.cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign bitTick = st.tick;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  property p_tick_gap;
    bitTick |=> !bitTick;
  endproperty
  a_tick_gap: assert property (p_tick_gap)
    else $error("bit ticks back to back");

  property p_tick_src;
    !modTick |=> !bitTick;
  endproperty
  a_tick_src: assert property (p_tick_src)
    else $error("bit tick without module clock tick");

  property p_div2;
    (restart && modTick && divSel == '0) ##1 (!restart && modTick)
      |=> bitTick;
  endproperty
  a_div2: assert property (p_div2)
    else $error("divide by two tick late");

endmodule : pte_div

// >>> rtl/pte_top.sv
// Summary of operation
// - square wave or 2..32 bit pattern
// - generators started together with the same divider setting change bits together
// - per-generator enable, set/clear registers, no banding
// - one write starts one or many generators
// - per-generator divider: 2, 4, 8 and up
// - module clock optionally from independent pin
// - single shot emits pattern once, stops
// - pattern repeats counted loops or forever
// - finished loop count restarts chosen generators
// - selected alternate function overrides gpio on pin
// - four generators, indexed zero to three
`timescale 1ns/1ps
module pte_top
  import pte_pkg::*;
(
  // clock and reset
  input  wire logic              mclk,
  input  wire logic              reset_n,
  // register port
  input  wire logic [ADDR_W-1:0] regAddr,
  input  wire logic [DATA_W-1:0] regWdata,
  input  wire logic              regWr,
  input  wire logic              regRd,
  output logic      [DATA_W-1:0] regRdata,
  // independent module clock pin
  input  wire logic              altClkPin,
  // ordinary gpio function of the four pins
  input  wire logic [NGEN-1:0]   gpioOut,
  input  wire logic [NGEN-1:0]   gpioOe,
  // pins
  output logic      [NGEN-1:0]   pinOut,
  output logic      [NGEN-1:0]   pinOe
);

  typedef struct packed {
    logic [NGEN-1:0]             en;
    logic [NGEN-1:0]             alt;
    logic [NGEN-1:0]             done;
    logic                        clkSel;
    logic                        sync1;
    logic                        sync2;
    logic                        sync3;
    pte_cfg_t [NGEN-1:0]         cfg;
    logic [NGEN-1:0][PAT_W-1:0]  pat;
    logic [NGEN-1:0][LOOP_W-1:0] loops;
    logic [NGEN-1:0][NGEN-1:0]   chain;
    pte_gen_t [NGEN-1:0]         gen;
    logic [NGEN-1:0]             pinOut;
    logic [NGEN-1:0]             pinOe;
    logic [DATA_W-1:0]           rdata;
  } pte_state_t;

  pte_state_t         st;
  pte_state_t         next_st;
  logic [NGEN-1:0]    bitTick;
  logic [NGEN-1:0]    finish;
  logic [NGEN-1:0]    start;
  logic [NGEN-1:0]    startReq;
  logic [NGEN-1:0]    chainReq;
  logic               modTick;
  logic               genHit;
  logic [GI_W-1:0]    gi;
  logic [1:0]         sub;

  // address split for the per-generator window
  assign genHit = (regAddr[ADDR_REG_LSB +: 2] == GEN_REGION);
  assign gi     = regAddr[ADDR_GEN_LSB +: GI_W];
  assign sub    = regAddr[ADDR_SUB_LSB +: 2];

  // one divider per generator keeps their rates apart
  for (genvar g = 0; g < NGEN; g++) begin : g_div
    pte_div u_div (
      .mclk    (mclk),
      .reset_n (reset_n),
      .modTick (modTick),
      .restart (start[g]),
      .divSel  (st.cfg[g].divSel),
      .bitTick (bitTick[g])
    );
  end

  // whole next state; bus writes first, then sequencing, then pins
  always_comb begin
    next_st  = st;
    startReq = '0;
    chainReq = '0;
    finish   = '0;
    start    = '0;

    // alt clock pin is synchronised; only sync2/sync3 are examined
    next_st.sync1 = altClkPin;
    next_st.sync2 = st.sync1;
    next_st.sync3 = st.sync2;
    modTick = st.clkSel ? (st.sync2 & ~st.sync3) : 1'b1;

    // register writes; set/clear words avoid read-modify-write races
    if (regWr) begin
      case (regAddr)
        REG_ENABLE: begin
          next_st.en = regWdata[NGEN-1:0];
        end
        REG_ENSET: begin
          next_st.en = st.en | regWdata[NGEN-1:0];
        end
        REG_ENCLR: begin
          next_st.en = st.en & ~regWdata[NGEN-1:0];
        end
        REG_START: begin
          startReq = regWdata[NGEN-1:0];
        end
        REG_CLKSEL: begin
          next_st.clkSel = regWdata[0];
        end
        REG_PINSEL: begin
          next_st.alt = regWdata[NGEN-1:0];
        end
        default: begin
          if (genHit) begin
            case (sub)
              SUB_CFG:   next_st.cfg[gi]   = wordToCfg(regWdata);
              SUB_PAT:   next_st.pat[gi]   = regWdata;
              SUB_LOOPS: next_st.loops[gi] = regWdata[LOOP_W-1:0];
              SUB_CHAIN: next_st.chain[gi] = regWdata[NGEN-1:0];
              default:   next_st.chain[gi] = st.chain[gi];
            endcase
          end
        end
      endcase
    end

    // a generator finishes on the tick that ends its last counted loop
    for (int i = 0; i < NGEN; i++) begin
      finish[i] = st.gen[i].running & bitTick[i]
                & (st.gen[i].idx >= effLenM1(st.cfg[i]))
                & (st.loops[i] != LOOP_FOREVER)
                & (st.gen[i].loopCnt + 1'b1 >= st.loops[i]);
      if (finish[i]) begin
        chainReq = chainReq | st.chain[i];
      end
    end

    // every start source lands in the same cycle, so groups align
    start = next_st.en
          & (startReq | (next_st.en & ~st.en) | chainReq);

    for (int i = 0; i < NGEN; i++) begin
      if (!next_st.en[i]) begin
        next_st.gen[i] = '0;
      end else if (start[i]) begin
        next_st.gen[i].running = 1'b1;
        next_st.gen[i].idx     = '0;
        next_st.gen[i].loopCnt = '0;
      end else if (st.gen[i].running && bitTick[i]) begin
        if (st.gen[i].idx >= effLenM1(st.cfg[i])) begin
          next_st.gen[i].idx = '0;
          if (finish[i]) begin
            next_st.gen[i].running = 1'b0;
          end else if (st.loops[i] != LOOP_FOREVER) begin
            next_st.gen[i].loopCnt = st.gen[i].loopCnt + 1'b1;
          end
        end else begin
          next_st.gen[i].idx = st.gen[i].idx + 1'b1;
        end
      end
      // hardware set wins over the clear made by a restart
      next_st.done[i] = finish[i] | (st.done[i] & ~start[i]);

      // pin mux; generator output supersedes gpio when selected
      if (next_st.alt[i]) begin
        next_st.pinOut[i] = next_st.gen[i].running
          ? patBit(next_st.cfg[i], next_st.pat[i], next_st.gen[i].idx)
          : next_st.cfg[i].idle;
        next_st.pinOe[i]  = 1'b1;
      end else begin
        next_st.pinOut[i] = gpioOut[i];
        next_st.pinOe[i]  = gpioOe[i];
      end
    end

    // read data stand only in the cycle after the strobe
    next_st.rdata = '0;
    if (regRd) begin
      case (regAddr)
        REG_ENABLE, REG_ENSET: next_st.rdata[NGEN-1:0] = st.en;
        REG_ENCLR:  next_st.rdata[NGEN-1:0] = st.en;
        REG_STATUS: begin
          for (int i = 0; i < NGEN; i++) begin
            next_st.rdata[i] = st.gen[i].running;
          end
          next_st.rdata[STAT_DONE_LSB +: NGEN] = st.done;
        end
        REG_CLKSEL: next_st.rdata[0] = st.clkSel;
        REG_PINSEL: next_st.rdata[NGEN-1:0] = st.alt;
        default: begin
          if (genHit) begin
            case (sub)
              SUB_CFG:   next_st.rdata = cfgToWord(st.cfg[gi]);
              SUB_PAT:   next_st.rdata = st.pat[gi];
              SUB_LOOPS: next_st.rdata[LOOP_W-1:0] = st.loops[gi];
              SUB_CHAIN: next_st.rdata[NGEN-1:0] = st.chain[gi];
              default:   next_st.rdata = '0;
            endcase
          end
        end
      endcase
    end
  end

  // single register stage for the whole block
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // outputs come straight from state flops
  assign regRdata = st.rdata;
  assign pinOut   = st.pinOut;
  assign pinOe    = st.pinOe;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  property p_len_range;
    st.gen[0].running |-> st.gen[0].idx <= effLenM1(st.cfg[0])
                       || !$stable(st.cfg[0]);
  endproperty
  a_len_range: assert property (p_len_range)
    else $error("bit index beyond pattern length");

  sequence s_group_start;
    start[0] && start[1] && st.cfg[0].divSel == st.cfg[1].divSel;
  endsequence

  property p_group_align;
    s_group_start |=> (bitTick[0] == bitTick[1]) [*8];
  endproperty
  a_group_align: assert property (p_group_align)
    else $error("grouped generators lost alignment");

  property p_disabled_stops;
    !st.en[0] |-> !st.gen[0].running;
  endproperty
  a_disabled_stops: assert property (p_disabled_stops)
    else $error("disabled generator still running");

  property p_start_write;
    (regWr && regAddr == REG_START && regWdata[1] && next_st.en[1])
      |=> st.gen[1].running && st.gen[1].idx == '0
          && st.gen[1].loopCnt == '0;
  endproperty
  a_start_write: assert property (p_start_write)
    else $error("start write did not restart generator");

  property p_single_shot;
    (finish[0] && st.loops[0] == 16'h0001 && !start[0])
      |=> !st.gen[0].running && st.done[0];
  endproperty
  a_single_shot: assert property (p_single_shot)
    else $error("single shot did not stop");

  property p_forever;
    (st.gen[2].running && st.loops[2] == LOOP_FOREVER && !regWr)
      |=> st.gen[2].running;
  endproperty
  a_forever: assert property (p_forever)
    else $error("endless generator stopped");

  sequence s_chain_fire;
    finish[0] && st.chain[0][1] && next_st.en[1];
  endsequence

  property p_chain;
    s_chain_fire |=> st.gen[1].running && st.gen[1].idx == '0;
  endproperty
  a_chain: assert property (p_chain)
    else $error("chained generator not restarted");

  property p_pin_owner;
    st.alt[0] |-> pinOe[0]
      && pinOut[0] == (st.gen[0].running
         ? patBit(st.cfg[0], st.pat[0], st.gen[0].idx) : st.cfg[0].idle);
  endproperty
  a_pin_owner: assert property (p_pin_owner)
    else $error("pin not driven by generator");

  property p_idle_level;
    (st.alt[1] && !st.en[1]) |-> pinOut[1] == st.cfg[1].idle;
  endproperty
  a_idle_level: assert property (p_idle_level)
    else $error("disabled generator not at idle level");

  // a pin-timed tick follows a rising pin edge two flops back
  property p_sync_delay;
    (st.clkSel && modTick)
      |-> $past(altClkPin, 2) && !$past(altClkPin, 3);
  endproperty
  a_sync_delay: assert property (p_sync_delay)
    else $error("module tick without pin edge");

  // set beats the clear of a restart in the same cycle
  property p_done_set;
    finish[1] |=> st.done[1];
  endproperty
  a_done_set: assert property (p_done_set)
    else $error("finish did not set done");

  // rising enable restarts from the first bit with a clean loop count
  property p_enable_restart;
    (!st.en[2] && next_st.en[2])
      |=> st.gen[2].running && st.gen[2].idx == '0
          && st.gen[2].loopCnt == '0;
  endproperty
  a_enable_restart: assert property (p_enable_restart)
    else $error("enable did not restart from bit zero");

  // between rate ticks a running generator keeps its bit
  property p_bit_hold;
    (st.gen[1].running && !bitTick[1] && !start[1] && next_st.en[1])
      |=> $stable(st.gen[1].idx);
  endproperty
  a_bit_hold: assert property (p_bit_hold)
    else $error("bit changed between rate ticks");

  // square mode shows one high bit, then one low bit
  property p_square;
    (st.alt[3] && st.gen[3].running && st.cfg[3].square)
      |-> pinOut[3] == (st.gen[3].idx == '0);
  endproperty
  a_square: assert property (p_square)
    else $error("square wave level wrong");

  // an unselected pin follows the ordinary gpio function a cycle later
  property p_gpio_pass;
    (!regWr && !st.alt[0])
      |=> pinOe[0] == $past(gpioOe[0]) && pinOut[0] == $past(gpioOut[0]);
  endproperty
  a_gpio_pass: assert property (p_gpio_pass)
    else $error("gpio function not passed to pin");

  // a disabled chain target ignores the restart
  property p_chain_refused;
    (finish[0] && st.chain[0][2] && !next_st.en[2])
      |=> !st.gen[2].running;
  endproperty
  a_chain_refused: assert property (p_chain_refused)
    else $error("disabled chain target started");

endmodule : pte_top

// >>> verification/pte_pin_load.sv
`timescale 1ns/1ps
module pte_pin_load
  import pte_pkg::*;
(
  // pins from the engine
  input  wire logic [NGEN-1:0] pinOut,
  input  wire logic [NGEN-1:0] pinOe,
  // level seen on the board
  output logic      [NGEN-1:0] padLevel
);
  // weak pull-down on every pad, so a released pad never keeps its last level
  assign padLevel = pinOut & pinOe;
endmodule : pte_pin_load

// >>> verification/tb_top.sv
`timescale 1ns/1ps
module tb_top
  import pte_pkg::*;
;
  // clock, reset and register port
  logic              mclk = 1'b0;
  logic              reset_n = 1'b0;
  logic [ADDR_W-1:0] regAddr = 8'h00;
  logic [DATA_W-1:0] regWdata = 32'h0;
  logic              regWr = 1'b0;
  logic              regRd = 1'b0;
  logic [DATA_W-1:0] regRdata;
  // module clock pin, gpio side and pads
  logic              altClkPin = 1'b0;
  logic [NGEN-1:0]   gpioOut = 4'h0;
  logic [NGEN-1:0]   gpioOe = 4'h0;
  logic [NGEN-1:0]   pinOut;
  logic [NGEN-1:0]   pinOe;
  logic [NGEN-1:0]   padLevel;
  // expected pattern and idle level per generator
  logic [PAT_W-1:0]  pats [NGEN];
  logic              idles [NGEN];
  int                miscompares = 0;
  int                totalChecks = 0;

  // 50 MHz system clock
  always #10 mclk = ~mclk;

  // module clock pin: six system cycles a period, phase unrelated
  initial begin
    #7;
    forever #60 altClkPin = ~altClkPin;
  end

  pte_top dut_u (
    .mclk     (mclk),
    .reset_n  (reset_n),
    .regAddr  (regAddr),
    .regWdata (regWdata),
    .regWr    (regWr),
    .regRd    (regRd),
    .regRdata (regRdata),
    .altClkPin(altClkPin),
    .gpioOut  (gpioOut),
    .gpioOe   (gpioOe),
    .pinOut   (pinOut),
    .pinOe    (pinOe)
  );

  pte_pin_load load_u (
    .pinOut  (pinOut),
    .pinOe   (pinOe),
    .padLevel(padLevel)
  );

  task automatic check(input logic [DATA_W-1:0] seen,
                       input logic [DATA_W-1:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic endSim;
    $display("checks %0d mismatches %0d", totalChecks, miscompares);
    if (miscompares == 0 && totalChecks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : endSim

  // one-cycle write; returns at the edge that takes it
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge mclk);
    regAddr  <= a;
    regWdata <= d;
    regWr    <= 1'b1;
    @(posedge mclk);
    regWr    <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    @(posedge mclk);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge mclk);
    regRd   <= 1'b0;
    @(negedge mclk);
    check(regRdata, exp);
  endtask : rd

  function automatic logic [ADDR_W-1:0] ga(input int g, input logic [1:0] s);
    return {GEN_REGION, g[1:0], s, 2'b00};
  endfunction : ga

  // disable, then program one generator
  task automatic cfg(input int g, input logic [4:0] lm1,
                     input logic [2:0] ds, input logic sq, input logic idl,
                     input logic [31:0] pat, input logic [15:0] lp,
                     input logic [3:0] ch);
    wr(REG_ENCLR, 32'(1 << g));
    wr(ga(g, SUB_CFG), {18'h0, idl, sq, 1'b0, ds, 3'h0, lm1});
    wr(ga(g, SUB_PAT), pat);
    wr(ga(g, SUB_LOOPS), {16'h0, lp});
    wr(ga(g, SUB_CHAIN), {28'h0, ch});
    pats[g]  = sq ? 32'h1 : pat;
    idles[g] = idl;
  endtask : cfg

  task automatic idleChk(input logic [3:0] m);
    for (int g = 0; g < NGEN; g++) begin
      if (m[g]) check(padLevel[g], idles[g]);
    end
  endtask : idleChk

  // every cycle of every bit is compared, so length and rate both show
  task automatic watch(input logic [3:0] m, input int len, input int div,
                       input int nbits);
    for (int b = 0; b < nbits; b++) begin
      for (int k = 0; k < div; k++) begin
        @(negedge mclk);
        for (int g = 0; g < NGEN; g++) begin
          if (m[g]) check(padLevel[g], pats[g][b % len]);
        end
      end
    end
  endtask : watch

  // idle before the enable; bit zero shows in the cycle after the write
  task automatic go(input logic [3:0] m, input int len, input int div,
                    input int nbits);
    @(negedge mclk);
    idleChk(m);
    wr(REG_ENSET, {28'h0, m});
    watch(m, len, div, nbits);
    @(negedge mclk);
    idleChk(m);
  endtask : go

  // main sequence
  initial begin
    int   n;
    logic v;
    repeat (20) @(posedge mclk);
    reset_n <= 1'b1;
    rd(REG_STATUS, 32'h0);
    rd(REG_ENABLE, 32'h0);
    rd(8'hfc, 32'h0);
    @(posedge mclk);
    gpioOut <= 4'ha;
    gpioOe  <= 4'h6;
    repeat (3) @(negedge mclk);
    check(pinOe, 4'h6);
    check(padLevel, 4'h2);
    wr(REG_PINSEL, 32'hf);
    rd(REG_PINSEL, 32'hf);
    check(pinOe, 4'hf);
    check(padLevel, 4'h0);
    for (int d = 0; d < 3; d++) begin
      cfg(0, 5'h03, d[2:0], 1'b0, 1'b1, 32'h6, 16'h1, 4'h0);
      go(4'h1, 4, 2 << d, 4);
      rd(REG_STATUS, 32'h10);
    end
    cfg(1, 5'h1f, 3'h0, 1'b0, 1'b0, 32'hc35a_9e61, 16'h1, 4'h0);
    go(4'h2, 32, 2, 32);
    cfg(1, 5'h00, 3'h0, 1'b0, 1'b0, 32'h1, 16'h1, 4'h0);
    go(4'h2, 2, 2, 2);
    cfg(2, 5'h02, 3'h0, 1'b0, 1'b0, 32'h5, 16'h3, 4'h0);
    go(4'h4, 3, 2, 9);
    cfg(3, 5'h00, 3'h1, 1'b1, 1'b0, 32'h0, 16'h2, 4'h0);
    go(4'h8, 2, 4, 4);
    // endless loop, stopped mid-pattern, then started over
    cfg(2, 5'h02, 3'h0, 1'b0, 1'b0, 32'h6, 16'h0, 4'h0);
    wr(REG_ENSET, 32'h4);
    watch(4'h4, 3, 2, 20);
    rd(REG_STATUS, 32'hb4);
    wr(REG_ENCLR, 32'h4);
    repeat (2) @(negedge mclk);
    idleChk(4'h4);
    wr(REG_ENSET, 32'h4);
    watch(4'h4, 3, 2, 4);
    // finish of gen0 restarts gen1; disabled gen2 stays idle
    cfg(1, 5'h01, 3'h0, 1'b0, 1'b0, 32'h1, 16'h1, 4'h0);
    cfg(0, 5'h01, 3'h0, 1'b0, 1'b0, 32'h1, 16'h1, 4'h6);
    rd(ga(0, SUB_CHAIN), 32'h6);
    wr(REG_ENCLR, 32'h4);
    wr(REG_ENSET, 32'h2);
    repeat (8) @(posedge mclk);
    wr(REG_ENSET, 32'h1);
    watch(4'h1, 2, 2, 2);
    watch(4'h2, 2, 2, 2);
    @(negedge mclk);
    idleChk(4'h7);
    // joint restart keeps two generators bit-aligned
    cfg(0, 5'h04, 3'h1, 1'b0, 1'b1, 32'h0d, 16'h0, 4'h0);
    cfg(1, 5'h04, 3'h1, 1'b0, 1'b0, 32'h16, 16'h0, 4'h0);
    wr(REG_ENSET, 32'h3);
    repeat (9) @(posedge mclk);
    wr(REG_START, 32'h7);
    watch(4'h3, 5, 4, 10);
    idleChk(4'h4);
    wr(REG_ENCLR, 32'h2);
    rd(REG_ENABLE, 32'h9);
    idleChk(4'h2);
    // bits timed by the module clock pin: 2 edges of 6 cycles
    wr(REG_CLKSEL, 32'h1);
    cfg(3, 5'h01, 3'h0, 1'b0, 1'b0, 32'h1, 16'h0, 4'h0);
    rd(ga(3, SUB_CFG), 32'h1);
    wr(REG_ENSET, 32'h8);
    repeat (30) @(negedge mclk);
    for (int k = 0; k < 2; k++) begin
      v = padLevel[3];
      n = 0;
      while (padLevel[3] === v && n < 100) begin
        @(negedge mclk);
        n++;
      end
    end
    check(n, 12);
    wr(REG_CLKSEL, 32'h0);
    wr(REG_ENABLE, 32'h6);
    rd(REG_ENABLE, 32'h6);
    wr(REG_ENABLE, 32'h0);
    rd(REG_ENABLE, 32'h0);
    endSim();
  end

  // watchdog: the sequence needs a few hundred cycles
  initial begin
    repeat (20000) @(posedge mclk);
    miscompares++;
    endSim();
  end
endmodule : tb_top
